// ---- jlpc_link_param_config.sv ----
// serial-port register bank for the link parameters, feeding the checker
`timescale 1ns/1ps
`default_nettype none
module jlpc_link_param_config
   import jlpc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdio_in,
   output logic spi_sdio_out,
   output logic spi_sdio_oe,
   input wire logic link_enable,
   output logic params_applied,
   output logic config_error,
   output logic descramble_enable,
   output logic [4:0] lanes_minus_one,
   output logic [7:0] octets_minus_one,
   output logic [4:0] frames_minus_one,
   output logic [7:0] converters_minus_one,
   output logic [2:0] subclass_version,
   output logic [4:0] configured_lane0_identifier
);
   jlpc_cfg_if cfg ();

   logic [7:0] regs_reg [NUM_REGS];
   logic [7:0] regs_next [NUM_REGS];
   jlpc_phase_t phase_reg, phase_next;
   logic sclk_reg, sclk_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [15:0] shift_reg, shift_next;
   logic rw_reg, rw_next;
   logic [14:0] addr_reg, addr_next;
   logic [7:0] out_reg, out_next;
   logic oe_reg, oe_next;
   logic rise, fall, wr_fire;
   logic [15:0] shifted;
   logic [2:0] wr_idx;
   logic [7:0] rd_data;

   // sclk is sampled on core_clk, so it must run well below half the core rate
   always_comb begin
      rise = spi_sclk && !sclk_reg && !spi_cs_n;
      fall = !spi_sclk && sclk_reg && !spi_cs_n;
      shifted = {shift_reg[14:0], spi_sdio_in};
      wr_idx = jlpc_idx(addr_reg);
      wr_fire = rise && phase_reg == JLPC_DATA && cnt_reg == FRAME_BITS - 5'h01 && !rw_reg && jlpc_hit(addr_reg);
      rd_data = jlpc_hit(addr_reg) ? regs_reg[jlpc_idx(addr_reg)] : 8'h00;
   end

   always_comb begin
      sclk_next = spi_sclk;
      phase_next = phase_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      rw_next = rw_reg;
      addr_next = addr_reg;
      out_next = out_reg;
      oe_next = oe_reg;
      if (spi_cs_n) begin
         phase_next = JLPC_IDLE;
         cnt_next = 5'h00;
         oe_next = 1'b0;
      end else begin
         unique case (phase_reg)
            JLPC_IDLE: begin
               phase_next = JLPC_INSTR;
            end
            JLPC_INSTR: begin
               if (rise) begin
                  shift_next = shifted;
                  cnt_next = cnt_reg + 5'h01;
                  if (cnt_reg == INSTR_BITS - 5'h01) begin
                     rw_next = shifted[RW_BIT];
                     addr_next = shifted[ADDR_W-1:0];
                     phase_next = JLPC_DATA;
                  end
               end
            end
            JLPC_DATA: begin
               if (rise) begin
                  shift_next = shifted;
                  cnt_next = cnt_reg + 5'h01;
                  if (cnt_reg == FRAME_BITS - 5'h01) begin
                     phase_next = JLPC_DONE;
                  end
               end else if (fall && rw_reg) begin
                  // first falling edge after the address loads the byte, later ones shift it
                  if (cnt_reg == INSTR_BITS && !oe_reg) begin
                     out_next = rd_data;
                     oe_next = 1'b1;
                  end else begin
                     out_next = {out_reg[6:0], 1'b0};
                  end
               end
            end
            JLPC_DONE: begin
               // extra clocks in one select window are ignored; single-byte access only
               if (fall) begin
                  oe_next = 1'b0;
               end
            end
         endcase
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_REGS; i++) begin
         regs_next[i] = regs_reg[i];
      end
      if (wr_fire) begin
         regs_next[wr_idx] = shifted[7:0] & REG_MASK[wr_idx];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_reg <= 1'b0;
         phase_reg <= JLPC_IDLE;
         cnt_reg <= 5'h00;
         shift_reg <= 16'h0000;
         rw_reg <= 1'b0;
         addr_reg <= 15'h0000;
         out_reg <= 8'h00;
         oe_reg <= 1'b0;
      end else begin
         sclk_reg <= sclk_next;
         phase_reg <= phase_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         rw_reg <= rw_next;
         addr_reg <= addr_next;
         out_reg <= out_next;
         oe_reg <= oe_next;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_regs
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               regs_reg[g] <= REG_RESET[g];
            end else begin
               regs_reg[g] <= regs_next[g];
            end
         end
         assign cfg.regs[g] = regs_reg[g];
      end
   endgenerate

   assign cfg.link_enable = link_enable;
   assign spi_sdio_out = out_reg[7];
   assign spi_sdio_oe = oe_reg;
   assign configured_lane0_identifier = regs_reg[IDX_LANE0_ADJ][LOW_MSB:0];

   jlpc_param_check u_check (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .cfg(cfg),
      .params_applied(params_applied),
      .config_error(config_error),
      .descramble_enable(descramble_enable),
      .lanes_minus_one(lanes_minus_one),
      .octets_minus_one(octets_minus_one),
      .frames_minus_one(frames_minus_one),
      .converters_minus_one(converters_minus_one),
      .subclass_version(subclass_version)
   );

   reg_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr_fire |=> regs_reg[$past(wr_idx)] == ($past(shifted[7:0]) & REG_MASK[$past(wr_idx)]))
      else $error("register write not stored");

   read_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      spi_sdio_oe |-> rw_reg && !spi_cs_n ##0 (cnt_reg >= INSTR_BITS))
      else $error("data pin driven outside a read");

   // the bit counter stops at one frame, so a long select window cannot wrap it
   cnt_bound_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      cnt_reg <= FRAME_BITS)
      else $error("bit counter ran past one frame");

   deselect_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      spi_cs_n |=> phase_reg == JLPC_IDLE && cnt_reg == 5'h00 && !spi_sdio_oe)
      else $error("port not idle after deselect");

   // first fall after the address loads the byte; later falls shift it
   read_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      fall && rw_reg && phase_reg == JLPC_DATA && cnt_reg == INSTR_BITS && !oe_reg
      |=> spi_sdio_oe && spi_sdio_out == $past(rd_data[7]))
      else $error("read byte not loaded");

   read_shift_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      fall && rw_reg && phase_reg == JLPC_DATA && cnt_reg > INSTR_BITS |=> spi_sdio_out == $past(out_reg[6]))
      else $error("read byte not shifted");

   miss_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      rw_reg && spi_sdio_oe && !jlpc_hit(addr_reg) |-> !spi_sdio_out)
      else $error("unmapped read not zero");

   lane0_store_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr_fire && wr_idx == IDX_LANE0_ADJ |=> configured_lane0_identifier == $past(shifted[LOW_MSB:0]))
      else $error("lane identifier not stored");

   adjust_store_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr_fire && wr_idx == IDX_LANE0_ADJ
      |=> regs_reg[IDX_LANE0_ADJ][ADJ_DIR_BIT] == $past(shifted[ADJ_DIR_BIT])
      && regs_reg[IDX_LANE0_ADJ][PHASE_ADJUST_REQUEST_BIT] == $past(shifted[PHASE_ADJUST_REQUEST_BIT]))
      else $error("adjust bits not stored");

   scr_store_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr_fire && wr_idx == IDX_SCR_LANES |=> regs_reg[IDX_SCR_LANES][SCR_BIT] == $past(shifted[SCR_BIT]))
      else $error("descramble bit not stored");

   reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (regs_reg[IDX_SCR_LANES] & ~REG_MASK[IDX_SCR_LANES]) == 8'h00
      && (regs_reg[IDX_FRAMES] & ~REG_MASK[IDX_FRAMES]) == 8'h00)
      else $error("reserved bits not zero");

   reg_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !wr_fire |=> $stable(regs_reg[IDX_OCTETS]) && $stable(regs_reg[IDX_CONVS]))
      else $error("register changed without a write");
endmodule
`default_nettype wire

// ---- jlpc_pkg.sv ----
// constants, register map and decode helpers for the link parameter bank
// Summary of operation
// - descramble lane data when the enable bit is one; bit resets to one
// - lanes field: 0 is one lane, 1 is two lanes; resets to 3
// - octets per frame field accepts 0, 1 or 3 only, 0 only with frames field 0x1f; resets to 0
// - frames per multiframe field accepts 0x0f or 0x1f only, 0x0f only with octets field 1 or 3; resets to 0x1f
// - converters field: 0 is one converter, 1 is two; resets to 1
// - subclass field: 0 is subclass 0, 1 is subclass 1; resets to 1
package jlpc_pkg;
   localparam int NUM_REGS = 7;
   localparam int ADDR_W = 15;
   localparam logic [14:0] ADDR_LANE0_ADJ = 15'h452;
   localparam logic [14:0] ADDR_SCR_LANES = 15'h453;
   localparam logic [14:0] ADDR_OCTETS = 15'h454;
   localparam logic [14:0] ADDR_FRAMES = 15'h455;
   localparam logic [14:0] ADDR_CONVS = 15'h456;
   localparam logic [14:0] ADDR_CS_RES = 15'h457;
   localparam logic [14:0] ADDR_SUB_NP = 15'h458;
   localparam int IDX_LANE0_ADJ = 0;
   localparam int IDX_SCR_LANES = 1;
   localparam int IDX_OCTETS = 2;
   localparam int IDX_FRAMES = 3;
   localparam int IDX_CONVS = 4;
   localparam int IDX_CS_RES = 5;
   localparam int IDX_SUB_NP = 6;
   // reset values, then writable-bit masks; reserved bits read zero
   localparam logic [7:0] REG_RESET [NUM_REGS] = '{8'h00, 8'h83, 8'h00, 8'h1f, 8'h01, 8'h0f, 8'h2f};
   localparam logic [7:0] REG_MASK [NUM_REGS] = '{8'h7f, 8'h9f, 8'hff, 8'h1f, 8'hff, 8'hdf, 8'hff};
   localparam int ADJ_DIR_BIT = 6;
   localparam int PHASE_ADJUST_REQUEST_BIT = 5;
   localparam int SCR_BIT = 7;
   localparam int LOW_MSB = 4;
   localparam int CS_MSB = 7;
   localparam int CS_LSB = 6;
   localparam int SUB_MSB = 7;
   localparam int SUB_LSB = 5;
   localparam logic [4:0] LANES_ONE = 5'h00;
   localparam logic [4:0] LANES_TWO = 5'h01;
   localparam logic [7:0] OCT_ONE = 8'h00;
   localparam logic [7:0] OCT_TWO = 8'h01;
   localparam logic [7:0] OCT_FOUR = 8'h03;
   localparam logic [4:0] FRAMES_16 = 5'h0f;
   localparam logic [4:0] FRAMES_32 = 5'h1f;
   localparam logic [7:0] CONV_ONE = 8'h00;
   localparam logic [7:0] CONV_TWO = 8'h01;
   localparam logic [1:0] CS_NONE = 2'h0;
   localparam logic [4:0] RES_16 = 5'h0f;
   localparam logic [4:0] NP_16 = 5'h0f;
   localparam logic [2:0] SUBCLASS_0 = 3'h0;
   localparam logic [2:0] SUBCLASS_1 = 3'h1;
   // serial port: 16-bit instruction (read flag, 15-bit address), then one data byte
   localparam logic [4:0] INSTR_BITS = 5'h10;
   localparam logic [4:0] FRAME_BITS = 5'h18;
   localparam int RW_BIT = 15;

   typedef enum logic [1:0] {
      JLPC_IDLE = 2'b00,
      JLPC_INSTR = 2'b01,
      JLPC_DATA = 2'b10,
      JLPC_DONE = 2'b11
   } jlpc_phase_t;

   function automatic logic jlpc_hit(input logic [14:0] a);
      return (a >= ADDR_LANE0_ADJ) && (a <= ADDR_SUB_NP);
   endfunction

   function automatic logic [2:0] jlpc_idx(input logic [14:0] a);
      logic [14:0] d;
      d = a - ADDR_LANE0_ADJ;
      return d[2:0];
   endfunction
endpackage

// ---- jlpc_cfg_if.sv ----
// carrier between the register bank and the parameter checker
`timescale 1ns/1ps
`default_nettype none
interface jlpc_cfg_if;
   logic [7:0] regs [jlpc_pkg::NUM_REGS];
   logic link_enable;
   modport bank (output regs, output link_enable);
   modport check (input regs, input link_enable);
endinterface
`default_nettype wire

// ---- jlpc_param_check.sv ----
// validates the programmed link parameters and applies them at link enable
`timescale 1ns/1ps
`default_nettype none
module jlpc_param_check
   import jlpc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   jlpc_cfg_if.check cfg,
   output logic params_applied,
   output logic config_error,
   output logic descramble_enable,
   output logic [4:0] lanes_minus_one,
   output logic [7:0] octets_minus_one,
   output logic [4:0] frames_minus_one,
   output logic [7:0] converters_minus_one,
   output logic [2:0] subclass_version
);
   logic [4:0] lanes_f, frames_f, res_f, np_f;
   logic [7:0] oct_f, conv_f;
   logic [1:0] cs_f;
   logic [2:0] sub_f;
   logic valid;
   logic applied_reg, applied_next, err_reg, err_next, scr_reg, scr_next;
   logic [4:0] lanes_reg, lanes_next, frames_reg, frames_next;
   logic [7:0] oct_reg, oct_next, conv_reg, conv_next;
   logic [2:0] sub_reg, sub_next;

   always_comb begin
      lanes_f = cfg.regs[IDX_SCR_LANES][LOW_MSB:0];
      oct_f = cfg.regs[IDX_OCTETS];
      frames_f = cfg.regs[IDX_FRAMES][LOW_MSB:0];
      conv_f = cfg.regs[IDX_CONVS];
      cs_f = cfg.regs[IDX_CS_RES][CS_MSB:CS_LSB];
      res_f = cfg.regs[IDX_CS_RES][LOW_MSB:0];
      sub_f = cfg.regs[IDX_SUB_NP][SUB_MSB:SUB_LSB];
      np_f = cfg.regs[IDX_SUB_NP][LOW_MSB:0];
      valid = (lanes_f == LANES_ONE || lanes_f == LANES_TWO)
         && (oct_f == OCT_ONE || oct_f == OCT_TWO || oct_f == OCT_FOUR)
         && (frames_f == FRAMES_16 || frames_f == FRAMES_32)
         && !(oct_f == OCT_ONE && frames_f == FRAMES_16)
         && (conv_f == CONV_ONE || conv_f == CONV_TWO)
         && (sub_f == SUBCLASS_0 || sub_f == SUBCLASS_1)
         && !cfg.regs[IDX_LANE0_ADJ][ADJ_DIR_BIT]
         && !cfg.regs[IDX_LANE0_ADJ][PHASE_ADJUST_REQUEST_BIT]
         && cs_f == CS_NONE && res_f == RES_16 && np_f == NP_16;
   end

   // parameters freeze while the link runs; a mid-link write waits for re-enable
   always_comb begin
      err_next = !valid;
      applied_next = applied_reg;
      scr_next = scr_reg;
      lanes_next = lanes_reg;
      oct_next = oct_reg;
      frames_next = frames_reg;
      conv_next = conv_reg;
      sub_next = sub_reg;
      if (!cfg.link_enable) begin
         applied_next = 1'b0;
      end else if (!applied_reg && valid) begin
         applied_next = 1'b1;
         scr_next = cfg.regs[IDX_SCR_LANES][SCR_BIT];
         lanes_next = lanes_f;
         oct_next = oct_f;
         frames_next = frames_f;
         conv_next = conv_f;
         sub_next = sub_f;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         applied_reg <= 1'b0;
         err_reg <= 1'b0;
         scr_reg <= REG_RESET[IDX_SCR_LANES][SCR_BIT];
         lanes_reg <= REG_RESET[IDX_SCR_LANES][LOW_MSB:0];
         oct_reg <= REG_RESET[IDX_OCTETS];
         frames_reg <= REG_RESET[IDX_FRAMES][LOW_MSB:0];
         conv_reg <= REG_RESET[IDX_CONVS];
         sub_reg <= REG_RESET[IDX_SUB_NP][SUB_MSB:SUB_LSB];
      end else begin
         applied_reg <= applied_next;
         err_reg <= err_next;
         scr_reg <= scr_next;
         lanes_reg <= lanes_next;
         oct_reg <= oct_next;
         frames_reg <= frames_next;
         conv_reg <= conv_next;
         sub_reg <= sub_next;
      end
   end

   assign params_applied = applied_reg;
   assign config_error = err_reg;
   assign descramble_enable = scr_reg;
   assign lanes_minus_one = lanes_reg;
   assign octets_minus_one = oct_reg;
   assign frames_minus_one = frames_reg;
   assign converters_minus_one = conv_reg;
   assign subclass_version = sub_reg;

   descr_apply_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(params_applied) |-> descramble_enable == $past(cfg.regs[IDX_SCR_LANES][SCR_BIT]))
      else $error("descramble enable not taken at link enable");
   lane_check_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (lanes_f > LANES_TWO) |=> config_error)
      else $error("illegal lane count not flagged");
   octet_check_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (oct_f == 8'h02 || oct_f > OCT_FOUR) |=> config_error)
      else $error("illegal octets per frame not flagged");
   frame_check_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (frames_f != FRAMES_16 && frames_f != FRAMES_32) |=> config_error && !$rose(params_applied))
      else $error("illegal frames per multiframe accepted");
   conv_check_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (conv_f > CONV_TWO) |=> config_error)
      else $error("illegal converter count not flagged");
   sub_apply_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(params_applied) |-> subclass_version <= SUBCLASS_1 && subclass_version == $past(sub_f))
      else $error("subclass applied wrongly");
   apply_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cfg.link_enable && params_applied) |=> params_applied && $stable(frames_minus_one) && $stable(octets_minus_one))
      else $error("parameters changed while link enabled");
endmodule
`default_nettype wire

// ---- jlpc_host_model.sv ----
// serial host model standing at the far side of the control port
`timescale 1ns/1ps
`default_nettype none
module jlpc_host_model (
   input wire logic core_clk,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_sdio_in,
   input wire logic spi_sdio_out,
   input wire logic spi_sdio_oe
);
   // sclk phase length in core cycles; raised to act as a slow host
   int half = 3;
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdio_in = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // one byte per chip-select window; sclk stands low outside frames
   task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wdata,
                       output logic [7:0] rdata);
      logic [23:0] frame;
      frame = {rd, addr, wdata};
      rdata = 8'h00;
      wait_clk(1);
      spi_cs_n = 1'b0;
      wait_clk(2);
      for (int i = 23; i >= 0; i--) begin
         spi_sdio_in = frame[i];
         wait_clk(half);
         // undriven line counts as unknown so a silent device never matches
         if (i < 8) rdata[i] = spi_sdio_oe ? spi_sdio_out : 1'bx;
         spi_sclk = 1'b1;
         wait_clk(half);
         spi_sclk = 1'b0;
      end
      wait_clk(half);
      spi_cs_n = 1'b1;
      spi_sdio_in = ~spi_sdio_in;
   endtask
endmodule
`default_nettype wire

// ---- tb_jlpc_link_param_config.sv ----
// self-checking bench for the link parameter register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; $display("[FAIL] t=%0t got %0h exp %0h", $time, a, e); end end
module tb_jlpc_link_param_config import jlpc_pkg::*;;
   logic core_clk, rst_n, spi_sclk, spi_cs_n, spi_sdio_in, spi_sdio_out, spi_sdio_oe, link_enable;
   logic params_applied, config_error, descramble_enable;
   logic [4:0] lanes_minus_one, frames_minus_one, configured_lane0_identifier;
   logic [7:0] octets_minus_one, converters_minus_one;
   logic [2:0] subclass_version;
   int checks = 0;
   int fails = 0;
   logic [14:0] addr_tab [7] = '{15'h452, 15'h453, 15'h454, 15'h455, 15'h456, 15'h457, 15'h458};
   logic [7:0] rst_tab [7] = '{8'h00, 8'h83, 8'h00, 8'h1f, 8'h01, 8'h0f, 8'h2f};
   logic [7:0] mask_tab [7] = '{8'h7f, 8'h9f, 8'hff, 8'h1f, 8'hff, 8'hdf, 8'hff};
   // reset leaves an unsupported lane count, so later checks start from two lanes
   logic [7:0] base_tab [7] = '{8'h00, 8'h81, 8'h00, 8'h1f, 8'h01, 8'h0f, 8'h2f};
   // {invalid, address, data}; all other registers at base values
   logic [23:0] code_tab [19] = '{
      {1'b0, 15'h454, 8'h01}, {1'b0, 15'h454, 8'h03}, {1'b1, 15'h454, 8'h02}, {1'b1, 15'h454, 8'h04},
      {1'b1, 15'h455, 8'h0e}, {1'b1, 15'h455, 8'h0f}, {1'b0, 15'h456, 8'h00}, {1'b1, 15'h456, 8'h02},
      {1'b0, 15'h453, 8'h01}, {1'b0, 15'h453, 8'h80}, {1'b1, 15'h453, 8'h02}, {1'b0, 15'h458, 8'h0f},
      {1'b1, 15'h458, 8'h4f}, {1'b1, 15'h452, 8'h40}, {1'b1, 15'h452, 8'h20}, {1'b0, 15'h452, 8'h15},
      {1'b1, 15'h457, 8'h4f}, {1'b1, 15'h457, 8'h0e}, {1'b1, 15'h458, 8'h2e}};

   jlpc_link_param_config jlpc_link_param_config_inst (.core_clk(core_clk), .rst_n(rst_n),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out),
      .spi_sdio_oe(spi_sdio_oe), .link_enable(link_enable), .params_applied(params_applied),
      .config_error(config_error), .descramble_enable(descramble_enable), .lanes_minus_one(lanes_minus_one),
      .octets_minus_one(octets_minus_one), .frames_minus_one(frames_minus_one),
      .converters_minus_one(converters_minus_one), .subclass_version(subclass_version),
      .configured_lane0_identifier(configured_lane0_identifier));
   jlpc_host_model jlpc_host_model_inst (.core_clk(core_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe(spi_sdio_oe));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] x;
      jlpc_host_model_inst.xfer(1'b0, a, d, x);
   endtask
   task automatic rd(input logic [14:0] a, output logic [7:0] d);
      jlpc_host_model_inst.xfer(1'b1, a, 8'h00, d);
   endtask
   task automatic test_reset();
      logic [7:0] d;
      for (int i = 0; i < 7; i++) begin
         rd(addr_tab[i], d);
         `CHK(d, rst_tab[i])
      end
      `CHK({descramble_enable, lanes_minus_one, octets_minus_one, frames_minus_one}, {1'b1, 5'h03, 8'h00, 5'h1f})
      `CHK({converters_minus_one, subclass_version}, {8'h01, 3'h1})
      // four lanes is not a supported code, so reset contents already flag an error
      `CHK({config_error, params_applied}, 2'b10)
      rd(15'h451, d);
      `CHK(d, 8'h00)
      rd(15'h459, d);
      `CHK(d, 8'h00)
      $display("test_reset done");
   endtask
   task automatic test_masks();
      logic [7:0] d;
      wr(15'h453, base_tab[1]);
      `CHK(config_error, 1'b0)
      for (int i = 0; i < 7; i++) begin
         wr(addr_tab[i], 8'hff);
         rd(addr_tab[i], d);
         `CHK(d, mask_tab[i])
         // all-ones is a legal code only for the multiframe length
         `CHK(config_error, (i != 3))
         if (i == 0) `CHK(configured_lane0_identifier, 5'h1f)
         wr(addr_tab[i], base_tab[i]);
      end
      $display("test_masks done");
   endtask
   task automatic test_codes();
      logic [14:0] a;
      for (int i = 0; i < 19; i++) begin
         a = code_tab[i][22:8];
         wr(a, code_tab[i][7:0]);
         `CHK(config_error, code_tab[i][23])
         link_enable = 1'b1;
         tick(3);
         `CHK(params_applied, ~code_tab[i][23])
         link_enable = 1'b0;
         tick(2);
         `CHK(params_applied, 1'b0)
         wr(a, base_tab[a - 15'h452]);
      end
      $display("test_codes done");
   endtask
   task automatic test_apply();
      jlpc_host_model_inst.half = 5;
      wr(15'h453, 8'h01);
      wr(15'h454, 8'h01);
      wr(15'h455, 8'h0f);
      wr(15'h456, 8'h00);
      wr(15'h458, 8'h0f);
      link_enable = 1'b1;
      `CHK(params_applied, 1'b0)
      tick(1);
      `CHK(params_applied, 1'b1)
      `CHK({descramble_enable, lanes_minus_one, octets_minus_one, frames_minus_one}, {1'b0, 5'h01, 8'h01, 5'h0f})
      `CHK({converters_minus_one, subclass_version}, {8'h00, 3'h0})
      // a running link must not see parameters change under it
      wr(15'h454, 8'h03);
      `CHK(octets_minus_one, 8'h01)
      link_enable = 1'b0;
      tick(1);
      `CHK({params_applied, octets_minus_one}, {1'b0, 8'h01})
      link_enable = 1'b1;
      tick(2);
      `CHK({params_applied, octets_minus_one}, {1'b1, 8'h03})
      link_enable = 1'b0;
      jlpc_host_model_inst.half = 3;
      for (int i = 1; i < 7; i++) wr(addr_tab[i], rst_tab[i]);
      $display("test_apply done");
   endtask
   task automatic print_verdict();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      // a full run takes well under a third of this span
      #1500000;
      fails++;
      print_verdict();
   end
   initial begin
      rst_n = 1'b0;
      link_enable = 1'b0;
      tick(2);
      rst_n = 1'b1;
      test_reset();
      test_masks();
      test_codes();
      test_apply();
      print_verdict();
   end
endmodule
`default_nettype wire
